/* core/cps_core_regs.sv */
// core pointer/status register file: stack top, data pointer, status word, accumulator
//
// Contract
// - stack top pointer resets to seven so first push lands at eight.
// - a push increments the stack top pointer before the byte is written.
// - low and high pointer bytes form a 16-bit pointer, both read/write.
// - carry flag set by add carry or subtract borrow, else cleared.
// - nibble carry flag set by carry into or borrow from upper nibble.
// - two bank bits pick register bank at 0x00, 0x08, 0x10 or 0x18.
// - range flag set by signed overflow of add, add-with-carry or subtract.
// - range flag set when a multiply product exceeds 255.
// - range flag set when dividing by zero.
// - range flag cleared by those instructions when no overflow occurs.
// - two user flags change only by software writes.
// - parity bit read-only; other status bits writable; status bit-addressable.
// - accumulator is byte-wide, bit-addressable, resets to zero.
`timescale 1ns/1ps
module cps_core_regs
   import cps_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // special register byte access
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // bit access
   input wire logic bit_wr,
   input wire logic [7:0] bit_addr,
   input wire logic bit_wdata,
   output logic bit_rdata,
   // stack operations
   input wire logic push,
   input wire logic pop,
   // datapath arithmetic and accumulator result
   input wire cps_op_t arith_op,
   input wire logic [7:0] arith_b,
   input wire logic acc_wr,
   input wire logic [7:0] acc_wdata,
   // state seen by the datapath
   output logic [7:0] stack_top_pointer,
   output logic [7:0] push_addr,
   output logic [15:0] data_pointer_16,
   output logic [7:0] main_arith_register,
   output logic [7:0] program_status_word,
   output logic [7:0] bank_base
);
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_a);
      hit = (a == reg_a);
   endfunction

   // bit address is byte base plus bit number; only bit-addressable bytes
   function automatic logic bit_hit(input logic [7:0] a, input logic [7:0] reg_a);
      bit_hit = ({a[7:3], 3'h0} == reg_a);
   endfunction

   function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] n, input logic b);
      logic [7:0] r;
      r = v;
      r[n] = b;
      set_bit = r;
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   logic [7:0] sp_q, sp_d;
   logic [7:0] dpl_q, dpl_d;
   logic [7:0] dph_q, dph_d;
   logic [7:0] acc_q, acc_d;
   logic [7:0] psw_q, psw_d;
   logic [7:0] rd_q, rd_d;
   logic brd_q, brd_d;
   logic [7:0] sp_o_q, pa_q, acc_o_q, psw_o_q, base_q;
   logic [15:0] dp_o_q;
   logic [7:0] acc_n;
   logic [7:0] psw_n;

   cps_flag_if fl ();

   cps_flag_unit u_flags (
      .op (arith_op),
      .opa (acc_q),
      .opb (arith_b),
      .cin (psw_q[CPS_CARRY_BIT]),
      .fl (fl)
   );

   // ************************************************************
   // next-state
   // ************************************************************
   always_comb begin
      sp_d = sp_q;
      dpl_d = dpl_q;
      dph_d = dph_q;
      acc_d = acc_q;
      psw_d = psw_q;
      if (push && !pop) begin
         sp_d = sp_q + 8'h01;
      end else if (pop && !push) begin
         sp_d = sp_q - 8'h01;
      end
      // datapath result first; software access takes precedence below
      if (acc_wr) begin
         acc_d = acc_wdata;
      end
      if (fl.upd_cy) begin
         psw_d[CPS_CARRY_BIT] = fl.cy;
      end
      if (fl.upd_ac) begin
         psw_d[CPS_NIBBLE_BIT] = fl.ac;
      end
      if (fl.upd_ov) begin
         psw_d[CPS_RANGE_BIT] = fl.ov;
      end
      if (sfr_wr) begin
         if (hit(sfr_addr, CPS_STACK_TOP_ADDR)) begin
            sp_d = sfr_wdata;
         end
         if (hit(sfr_addr, CPS_PTR_LOW_ADDR)) begin
            dpl_d = sfr_wdata;
         end
         if (hit(sfr_addr, CPS_PTR_HIGH_ADDR)) begin
            dph_d = sfr_wdata;
         end
         if (hit(sfr_addr, CPS_STATUS_ADDR)) begin
            psw_d = sfr_wdata;
         end
         if (hit(sfr_addr, CPS_ARITH_ADDR)) begin
            acc_d = sfr_wdata;
         end
      end
      if (bit_wr) begin
         if (bit_hit(bit_addr, CPS_STATUS_ADDR)) begin
            psw_d = set_bit(psw_d, bit_addr[2:0], bit_wdata);
         end
         if (bit_hit(bit_addr, CPS_ARITH_ADDR)) begin
            acc_d = set_bit(acc_d, bit_addr[2:0], bit_wdata);
         end
      end
      psw_d[CPS_PARITY_BIT] = ^acc_d;
      acc_n = acc_d;
      psw_n = psw_d;
      // read data registered for output
      rd_d = 8'h00;
      if (sfr_rd) begin
         if (hit(sfr_addr, CPS_STACK_TOP_ADDR)) begin
            rd_d = sp_q;
         end else if (hit(sfr_addr, CPS_PTR_LOW_ADDR)) begin
            rd_d = dpl_q;
         end else if (hit(sfr_addr, CPS_PTR_HIGH_ADDR)) begin
            rd_d = dph_q;
         end else if (hit(sfr_addr, CPS_STATUS_ADDR)) begin
            rd_d = psw_q;
         end else if (hit(sfr_addr, CPS_ARITH_ADDR)) begin
            rd_d = acc_q;
         end else begin
            rd_d = 8'h00;
         end
      end
      brd_d = 1'b0;
      if (bit_hit(bit_addr, CPS_STATUS_ADDR)) begin
         brd_d = psw_q[bit_addr[2:0]];
      end else if (bit_hit(bit_addr, CPS_ARITH_ADDR)) begin
         brd_d = acc_q[bit_addr[2:0]];
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sp_q <= CPS_STACK_TOP_RST;
         dpl_q <= CPS_PTR_LOW_RST;
         dph_q <= CPS_PTR_HIGH_RST;
         acc_q <= CPS_ARITH_RST;
         psw_q <= CPS_STATUS_RST;
         rd_q <= 8'h00;
         brd_q <= 1'b0;
         sp_o_q <= CPS_STACK_TOP_RST;
         pa_q <= CPS_STACK_TOP_RST + 8'h01;
         dp_o_q <= {CPS_PTR_HIGH_RST, CPS_PTR_LOW_RST};
         acc_o_q <= CPS_ARITH_RST;
         psw_o_q <= CPS_STATUS_RST;
         base_q <= 8'h00;
      end else begin
         sp_q <= sp_d;
         dpl_q <= dpl_d;
         dph_q <= dph_d;
         acc_q <= acc_n;
         psw_q <= psw_n;
         rd_q <= rd_d;
         brd_q <= brd_d;
         // outputs mirror the next state so they track the internal registers
         sp_o_q <= sp_d;
         // push address is pointer plus one
         pa_q <= sp_d + 8'h01;
         dp_o_q <= {dph_d, dpl_d};
         acc_o_q <= acc_n;
         psw_o_q <= psw_n;
         base_q <= CPS_BANK_STRIDE * {6'h00, psw_n[CPS_BANK_HI_BIT:CPS_BANK_LO_BIT]};
      end
   end

   assign sfr_rdata = rd_q;
   assign bit_rdata = brd_q;
   assign stack_top_pointer = sp_o_q;
   assign push_addr = pa_q;
   assign data_pointer_16 = dp_o_q;
   assign main_arith_register = acc_o_q;
   assign program_status_word = psw_o_q;
   assign bank_base = base_q;
endmodule // cps_core_regs

/* core/cps_flag_if.sv */
// interface: flag results passed from the flag unit to the register file
`timescale 1ns/1ps
interface cps_flag_if;
   logic upd_cy;
   logic cy;
   logic upd_ac;
   logic ac;
   logic upd_ov;
   logic ov;
   modport src (output upd_cy, cy, upd_ac, ac, upd_ov, ov);
   modport dst (input upd_cy, cy, upd_ac, ac, upd_ov, ov);
endinterface

/* core/cps_flag_unit.sv */
// flag unit: carry, nibble carry and range flags from an arithmetic operation
`timescale 1ns/1ps
module cps_flag_unit
   import cps_pkg::*;
(
   // operation
   input wire cps_op_t op,
   input wire logic [7:0] opa,
   input wire logic [7:0] opb,
   input wire logic cin,
   // results
   cps_flag_if.src fl
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [15:0] prod;
   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      prod = opa * opb;
      fl.upd_cy = 1'b0;
      fl.cy = 1'b0;
      fl.upd_ac = 1'b0;
      fl.ac = 1'b0;
      fl.upd_ov = 1'b0;
      fl.ov = 1'b0;
      case (op)
         CPS_OP_ADD, CPS_OP_ADDC: begin
            sum = {1'b0, opa} + {1'b0, opb} + {8'h00, (op == CPS_OP_ADDC) & cin};
            nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, (op == CPS_OP_ADDC) & cin};
            fl.upd_cy = 1'b1;
            fl.cy = sum[8];
            fl.upd_ac = 1'b1;
            fl.ac = nib[4];
            fl.upd_ov = 1'b1;
            fl.ov = (opa[7] == opb[7]) && (sum[7] != opa[7]);
         end
         CPS_OP_SUBB: begin
            sum = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
            nib = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
            fl.upd_cy = 1'b1;
            fl.cy = sum[8];
            fl.upd_ac = 1'b1;
            fl.ac = nib[4];
            fl.upd_ov = 1'b1;
            fl.ov = (opa[7] != opb[7]) && (sum[7] != opa[7]);
         end
         CPS_OP_MUL: begin
            fl.upd_cy = 1'b1;
            fl.upd_ov = 1'b1;
            fl.ov = (prod[15:8] != 8'h00);
         end
         CPS_OP_DIV: begin
            fl.upd_cy = 1'b1;
            fl.upd_ov = 1'b1;
            fl.ov = (opb == 8'h00);
         end
         CPS_OP_OTHER: begin
            fl.upd_cy = 1'b1;
            fl.upd_ac = 1'b1;
         end
         default: begin
            fl.upd_cy = 1'b0;
         end
      endcase
   end
endmodule // cps_flag_unit

/* core/cps_pkg.sv */
// package: offsets, fields, reset values and opcodes of the core pointer/status registers
package cps_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] CPS_STACK_TOP_ADDR = 8'h81;
   localparam logic [7:0] CPS_PTR_LOW_ADDR = 8'h82;
   localparam logic [7:0] CPS_PTR_HIGH_ADDR = 8'h83;
   localparam logic [7:0] CPS_STATUS_ADDR = 8'hd0;
   localparam logic [7:0] CPS_ARITH_ADDR = 8'hf0;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] CPS_STACK_TOP_RST = 8'h07;
   localparam logic [7:0] CPS_PTR_LOW_RST = 8'h00;
   localparam logic [7:0] CPS_PTR_HIGH_RST = 8'h00;
   localparam logic [7:0] CPS_STATUS_RST = 8'h00;
   localparam logic [7:0] CPS_ARITH_RST = 8'h00;
   // ************************************************************
   // status word fields
   // ************************************************************
   localparam int CPS_CARRY_BIT = 7;
   localparam int CPS_NIBBLE_BIT = 6;
   localparam int CPS_UFLAG0_BIT = 5;
   localparam int CPS_BANK_HI_BIT = 4;
   localparam int CPS_BANK_LO_BIT = 3;
   localparam int CPS_RANGE_BIT = 2;
   localparam int CPS_UFLAG1_BIT = 1;
   localparam int CPS_PARITY_BIT = 0;
   localparam logic [7:0] CPS_BANK_STRIDE = 8'h08;
   // ************************************************************
   // arithmetic operations reported by the datapath
   // ************************************************************
   typedef enum logic [2:0] {
      CPS_OP_NONE = 3'h0,
      CPS_OP_ADD = 3'h1,
      CPS_OP_ADDC = 3'h2,
      CPS_OP_SUBB = 3'h3,
      CPS_OP_MUL = 3'h4,
      CPS_OP_DIV = 3'h5,
      CPS_OP_OTHER = 3'h6
   } cps_op_t;
endpackage

/* tb/cps_core_regs_bench.sv */
// bench: random and corner stimulus for the core pointer/status registers
`timescale 1ns/1ps
module cps_core_regs_bench
   import cps_pkg::*;
;
   // ************************************************************
   // stimulus and checks
   // ************************************************************
   logic sys_clk, rst_n, sfr_wr, sfr_rd, bit_wr, bit_wdata, bit_rdata, push, pop, acc_wr;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, arith_b, acc_wdata, stack_top_pointer, push_addr;
   logic [7:0] main_arith_register, program_status_word, bank_base, a, b, p;
   logic [15:0] data_pointer_16, d;
   logic [31:0] r;
   logic [31:0] seed = 32'hf803ecab;
   cps_op_t arith_op, op;
   int mismatches = 0, n_compared = 0, cycles = 0;
   cps_core_regs cps_core_regs_i (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_wr(bit_wr), .bit_addr(bit_addr),
      .bit_wdata(bit_wdata), .bit_rdata(bit_rdata), .push(push), .pop(pop), .arith_op(arith_op), .arith_b(arith_b),
      .acc_wr(acc_wr), .acc_wdata(acc_wdata), .stack_top_pointer(stack_top_pointer), .push_addr(push_addr),
      .data_pointer_16(data_pointer_16), .main_arith_register(main_arith_register),
      .program_status_word(program_status_word), .bank_base(bank_base));
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected status word after one operation
   function automatic logic [7:0] exp_psw(cps_op_t o, logic [7:0] x, logic [7:0] y, logic [7:0] q);
      logic [8:0] s;
      logic [4:0] n;
      logic c;
      c = (o == CPS_OP_ADDC || o == CPS_OP_SUBB) ? q[7] : 1'b0;
      case (o)
         CPS_OP_ADD, CPS_OP_ADDC: begin
            s = {1'b0, x} + {1'b0, y} + 9'(c);
            n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + 5'(c);
            q[2] = (x[7] == y[7]) && (s[7] != x[7]);
         end
         CPS_OP_SUBB: begin
            s = {1'b0, x} - {1'b0, y} - 9'(c);
            n = {1'b0, x[3:0]} - {1'b0, y[3:0]} - 5'(c);
            q[2] = (x[7] != y[7]) && (s[7] != x[7]);
         end
         CPS_OP_MUL: q[2] = ({8'h00, x} * {8'h00, y}) > 16'h00ff;
         CPS_OP_DIV: q[2] = (y == 8'h00);
         default: ;
      endcase
      if (o inside {CPS_OP_ADD, CPS_OP_ADDC, CPS_OP_SUBB}) begin
         q[7] = s[8];
         q[6] = n[4];
      end
      if (o inside {CPS_OP_MUL, CPS_OP_DIV, CPS_OP_OTHER}) q[7] = 1'b0;
      if (o == CPS_OP_OTHER) q[6] = 1'b0;
      q[0] = ^x;
      return q;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      sfr_wr = 1;
      sfr_addr = ad;
      sfr_wdata = dt;
      tick();
      sfr_wr = 0;
      tick();
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      sfr_rd = 1;
      sfr_addr = ad;
      tick();
      sfr_rd = 0;
      chk(sfr_rdata, e);
      tick();
   endtask
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // cut a hang short; the run needs about eight hundred fifty cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      {rst_n, sfr_wr, sfr_rd, bit_wr, bit_wdata, push, pop, acc_wr} = 8'h00;
      {sfr_addr, sfr_wdata, bit_addr, arith_b, acc_wdata} = 40'h0;
      arith_op = CPS_OP_NONE;
      repeat (12) @(posedge sys_clk);
      #1;
      rst_n = 1;
      rd(CPS_STACK_TOP_ADDR, 8'h07);
      chk(push_addr, 8'h08);
      rd(CPS_ARITH_ADDR, 8'h00);
      rd(CPS_STATUS_ADDR, 8'h00);
      rd(8'h84, 8'h00);
      d = 16'(rnd());
      wr(CPS_PTR_LOW_ADDR, d[7:0]);
      wr(CPS_PTR_HIGH_ADDR, d[15:8]);
      chk(data_pointer_16, d);
      rd(CPS_PTR_LOW_ADDR, d[7:0]);
      // stack wrap, back-to-back pushes, push with pop, pop
      wr(CPS_STACK_TOP_ADDR, 8'hfe);
      push = 1;
      tick();
      tick();
      chk(stack_top_pointer, 8'h00);
      pop = 1;
      tick();
      push = 0;
      chk(stack_top_pointer, 8'h00);
      tick();
      pop = 0;
      chk(stack_top_pointer, 8'hff);
      wr(CPS_STATUS_ADDR, 8'hff);
      rd(CPS_STATUS_ADDR, 8'hfe);
      for (int k = 0; k < 4; k++) begin
         wr(CPS_STATUS_ADDR, 8'(k << 3));
         chk(bank_base, 8'(k * 8));
      end
      // bit writes: user flag takes, parity bit ignores
      bit_wr = 1;
      bit_wdata = 1;
      bit_addr = 8'hd1;
      tick();
      bit_addr = 8'hd0;
      tick();
      bit_wr = 0;
      bit_addr = 8'hd4;
      chk(program_status_word, 8'h1a);
      tick();
      chk(bit_rdata, 1'b1);
      for (int i = 0; i < 200; i++) begin
         r = rnd();
         p = r[7:0] & 8'hfe;
         a = r[15:8];
         b = (i % 8 == 0) ? 8'h00 : r[23:16];
         op = cps_op_t'(3'(1 + r[31:24] % 6));
         wr(CPS_STATUS_ADDR, p);
         acc_wr = 1;
         acc_wdata = a;
         tick();
         acc_wr = 0;
         chk(main_arith_register, a);
         arith_op = op;
         arith_b = b;
         tick();
         arith_op = CPS_OP_NONE;
         chk(program_status_word, exp_psw(op, a, b, p));
      end
      close_out();
   end
endmodule // cps_core_regs_bench

/* tb/cps_core_regs_monitor.sv */
// checker: port relations of the core pointer/status registers
`timescale 1ns/1ps
module cps_core_regs_monitor
   import cps_pkg::*;
(
   // watched ports
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic bit_wr,
   input wire logic push,
   input wire logic pop,
   input wire cps_op_t arith_op,
   input wire logic [7:0] arith_b,
   input wire logic [7:0] stack_top_pointer,
   input wire logic [7:0] push_addr,
   input wire logic [15:0] data_pointer_16,
   input wire logic [7:0] main_arith_register,
   input wire logic [7:0] program_status_word,
   input wire logic [7:0] bank_base
);
   // ************************************************************
   // helpers and assertions
   // ************************************************************
   // software writes win, so hardware checks skip those cycles
   wire sw_idle = !sfr_wr && !bit_wr;
   wire [8:0] add_sum = {1'b0, main_arith_register} + {1'b0, arith_b};
   wire [4:0] nib_sum = {1'b0, main_arith_register[3:0]} + {1'b0, arith_b[3:0]};
   wire [15:0] mul_prod = {8'h00, main_arith_register} * {8'h00, arith_b};
   wire add_ovf = (main_arith_register[7] == arith_b[7]) && (add_sum[7] != main_arith_register[7]);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_push_step: assert property (push && !pop && sw_idle |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
      else $error("push did not step pointer");
   a_push_target: assert property (push_addr == stack_top_pointer + 8'h01)
      else $error("push target wrong");
   a_ptr_low: assert property (sfr_wr && sfr_addr == CPS_PTR_LOW_ADDR |=> data_pointer_16[7:0] == $past(sfr_wdata))
      else $error("pointer low byte not written");
   a_bank_map: assert property (bank_base == {3'h0, program_status_word[4:3], 3'h0})
      else $error("bank base wrong");
   a_parity_track: assert property (program_status_word[0] == ^main_arith_register)
      else $error("parity wrong");
   a_add_carry: assert property (arith_op == CPS_OP_ADD && sw_idle |=>
      program_status_word[7] == $past(add_sum[8]) && program_status_word[6] == $past(nib_sum[4])) else $error("add carry wrong");
   a_add_range: assert property (arith_op == CPS_OP_ADD && sw_idle |=> program_status_word[2] == $past(add_ovf))
      else $error("add range flag wrong");
   a_mul_range: assert property (arith_op == CPS_OP_MUL && sw_idle |=> program_status_word[2] == $past(mul_prod > 16'h00ff))
      else $error("mul range flag wrong");
   a_div_range: assert property (arith_op == CPS_OP_DIV && sw_idle |=> program_status_word[2] == $past(arith_b == 8'h00))
      else $error("div range flag wrong");
   a_user_hold: assert property (sw_idle |=> $stable(program_status_word[5:3]) && $stable(program_status_word[1]))
      else $error("user flag or bank moved");
endmodule // cps_core_regs_monitor
bind cps_core_regs cps_core_regs_monitor cps_core_regs_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_wr(sfr_wr),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .bit_wr(bit_wr), .push(push), .pop(pop), .arith_op(arith_op),
   .arith_b(arith_b), .stack_top_pointer(stack_top_pointer), .push_addr(push_addr), .data_pointer_16(data_pointer_16),
   .main_arith_register(main_arith_register), .program_status_word(program_status_word), .bank_base(bank_base));
